// ---- src/dcf_pkg.sv ----
/*
 * package for one channel of the dual-clock 9-bit fifo: widths, defaults,
 * register map, event bits, bus carrier and the channel state record.
 * assumes the largest channel depth is 8192 words.
 */
package dcf_pkg;
    localparam int DATA_W = 9;
    localparam int PTR_W = 13;
    localparam int CNT_W = 14;
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;
    localparam int EVT_W = 4;
    localparam int DEPTH_DEFAULT = 256;

    // offsets come out of reset as empty+7 and full-7
    localparam logic [CNT_W-1:0] AE_OFFSET_RESET = 14'h0007;
    localparam logic [CNT_W-1:0] AF_OFFSET_RESET = 14'h0007;

    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_AE_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] REG_AF_OFFSET = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h14;

    localparam int EVT_WR_REFUSED = 0;
    localparam int EVT_RD_REFUSED = 1;
    localparam int EVT_FULL = 2;
    localparam int EVT_EMPTY = 3;

    localparam logic [BUS_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam logic [EVT_W-1:0] EVT_NONE = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BUS_W-1:0] wdata;
        logic wr;
        logic rd;
    } dcf_bus_req_type;

    typedef struct packed {
        logic emptyN;
        logic almostEmptyN;
        logic fullN;
        logic almostFullN;
    } dcf_flags_type;

    typedef struct packed {
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] aeOffset;
        logic [CNT_W-1:0] afOffset;
        logic strapped;
        logic dualMode;
        logic wclkPrev;
        logic rclkPrev;
        logic loadSelAf;
        logic [DATA_W-1:0] readData;
        dcf_flags_type flags;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic [BUS_W-1:0] rdata;
    } dcf_state_type;
endpackage : dcf_pkg

// ---- src/dcf_channel.sv ----
/*
 * one channel of a dual-clock 9-bit fifo with empty, full and programmable
 * almost flags, a strap-selected second write enable or offset load pin,
 * and a small register port with a level interrupt.
 * assumes write_clock and read_clock arrive as levels synchronous to clk;
 * their rising edges, seen on clk, are the write and read strobes.
 */
`timescale 1ns/1ps
module dcf_channel #(
    parameter int DEPTH = dcf_pkg::DEPTH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic write_clock,
    input wire logic firstWriteEnableN,
    input wire logic secondWriteEnableLoadN,
    input wire logic [dcf_pkg::DATA_W-1:0] writeDataIn,
    input wire logic read_clock,
    input wire logic firstReadEnableN,
    input wire logic secondReadEnableN,
    input wire logic outputDriveEnableN,
    output logic [dcf_pkg::DATA_W-1:0] readDataOut,
    output logic readDataOutEn,
    output logic emptyFlagN,
    output logic almostEmptyFlagN,
    output logic fullFlagN,
    output logic almostFullFlagN,
    input wire dcf_pkg::dcf_bus_req_type busReq,
    output logic [dcf_pkg::BUS_W-1:0] busRdata,
    output logic irq
);
    localparam int ADDR_BITS = $clog2(DEPTH);
    localparam logic [dcf_pkg::PTR_W-1:0] LAST_PTR = dcf_pkg::PTR_W'(DEPTH - 1);
    localparam logic [dcf_pkg::CNT_W-1:0] DEPTH_CNT = dcf_pkg::CNT_W'(DEPTH);

    dcf_pkg::dcf_state_type s_r;
    dcf_pkg::dcf_state_type s_nxt;
    logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];
    logic [dcf_pkg::DATA_W-1:0] memRd;
    logic wclkRise;
    logic rclkRise;
    logic loadActive;
    logic wrReq;
    logic doLoad;
    logic doWrite;
    logic wrRefused;
    logic rdReq;
    logic doRead;
    logic [dcf_pkg::CNT_W-1:0] countNxt;
    logic [dcf_pkg::EVT_W-1:0] events;
    logic [dcf_pkg::EVT_W-1:0] clearBits;

    function automatic logic [dcf_pkg::PTR_W-1:0] ptrInc(input logic [dcf_pkg::PTR_W-1:0] p);
        ptrInc = (p == LAST_PTR) ? '0 : dcf_pkg::PTR_W'(p + 1'b1);
    endfunction : ptrInc

    function automatic logic [dcf_pkg::BUS_W-1:0] widen(input logic [dcf_pkg::CNT_W-1:0] v);
        widen = dcf_pkg::BUS_W'(v);
    endfunction : widen

    assign memRd = mem[s_r.rdPtr[ADDR_BITS-1:0]];

    always_comb begin
        s_nxt = s_r;
        wclkRise = write_clock & ~s_r.wclkPrev;
        rclkRise = read_clock & ~s_r.rclkPrev;
        s_nxt.wclkPrev = write_clock;
        s_nxt.rclkPrev = read_clock;

        // shared pin sampled once, in the first cycle after reset release
        if (!s_r.strapped) begin
            s_nxt.strapped = 1'b1;
            s_nxt.dualMode = secondWriteEnableLoadN;
        end

        loadActive = s_r.strapped & ~s_r.dualMode & ~secondWriteEnableLoadN;
        wrReq = wclkRise & s_r.strapped & ~firstWriteEnableN
              & (~s_r.dualMode | secondWriteEnableLoadN);
        doLoad = wrReq & loadActive;
        doWrite = wrReq & ~loadActive & s_r.flags.fullN;
        wrRefused = wrReq & ~loadActive & ~s_r.flags.fullN;
        rdReq = rclkRise & ~firstReadEnableN & ~secondReadEnableN;
        doRead = rdReq & s_r.flags.emptyN;

        // a load write fills almost-empty first, then almost-full, in turn
        if (doLoad) begin
            if (s_r.loadSelAf) begin
                s_nxt.afOffset = dcf_pkg::CNT_W'(writeDataIn);
            end else begin
                s_nxt.aeOffset = dcf_pkg::CNT_W'(writeDataIn);
            end
            s_nxt.loadSelAf = ~s_r.loadSelAf;
        end
        if (!loadActive) begin
            s_nxt.loadSelAf = 1'b0;
        end

        if (doWrite) begin
            s_nxt.wrPtr = ptrInc(s_r.wrPtr);
        end
        if (doRead) begin
            s_nxt.rdPtr = ptrInc(s_r.rdPtr);
            s_nxt.readData = memRd;
        end

        // bus offset writes land before the flags so they judge the new offset
        clearBits = dcf_pkg::EVT_NONE;
        if (busReq.wr) begin
            unique case (busReq.addr)
                dcf_pkg::REG_STATUS: clearBits = busReq.wdata[dcf_pkg::EVT_W-1:0];
                dcf_pkg::REG_MASK: s_nxt.mask = busReq.wdata[dcf_pkg::EVT_W-1:0];
                dcf_pkg::REG_AE_OFFSET: s_nxt.aeOffset = busReq.wdata[dcf_pkg::CNT_W-1:0];
                dcf_pkg::REG_AF_OFFSET: s_nxt.afOffset = busReq.wdata[dcf_pkg::CNT_W-1:0];
                default: ;
            endcase
        end

        // one shared counter, so both flag groups see the same true level
        countNxt = s_r.count;
        if (doWrite && !doRead) begin
            countNxt = dcf_pkg::CNT_W'(s_r.count + 1'b1);
        end else if (doRead && !doWrite) begin
            countNxt = dcf_pkg::CNT_W'(s_r.count - 1'b1);
        end
        s_nxt.count = countNxt;
        s_nxt.flags.emptyN = (countNxt != '0);
        s_nxt.flags.almostEmptyN = (countNxt > s_nxt.aeOffset);
        s_nxt.flags.fullN = (countNxt != DEPTH_CNT);
        s_nxt.flags.almostFullN = (countNxt < dcf_pkg::CNT_W'(DEPTH_CNT - s_nxt.afOffset));

        events = dcf_pkg::EVT_NONE;
        events[dcf_pkg::EVT_WR_REFUSED] = wrRefused;
        events[dcf_pkg::EVT_RD_REFUSED] = rdReq & ~s_r.flags.emptyN;
        events[dcf_pkg::EVT_FULL] = s_r.flags.fullN & ~s_nxt.flags.fullN;
        events[dcf_pkg::EVT_EMPTY] = s_r.flags.emptyN & ~s_nxt.flags.emptyN;

        // a fresh event beats a clear in the same cycle
        s_nxt.status = (s_r.status & ~clearBits) | events;

        s_nxt.rdata = dcf_pkg::READ_ZERO;
        if (busReq.rd) begin
            unique case (busReq.addr)
                dcf_pkg::REG_STATUS: s_nxt.rdata = dcf_pkg::BUS_W'(s_r.status);
                dcf_pkg::REG_MASK: s_nxt.rdata = dcf_pkg::BUS_W'(s_r.mask);
                dcf_pkg::REG_AE_OFFSET: s_nxt.rdata = widen(s_r.aeOffset);
                dcf_pkg::REG_AF_OFFSET: s_nxt.rdata = widen(s_r.afOffset);
                dcf_pkg::REG_LEVEL: s_nxt.rdata = widen(s_r.count);
                dcf_pkg::REG_CONFIG: s_nxt.rdata = dcf_pkg::BUS_W'(s_r.dualMode);
                default: s_nxt.rdata = dcf_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.wrPtr <= '0;
            s_r.rdPtr <= '0;
            s_r.count <= '0;
            s_r.aeOffset <= dcf_pkg::AE_OFFSET_RESET;
            s_r.afOffset <= dcf_pkg::AF_OFFSET_RESET;
            s_r.strapped <= 1'b0;
            s_r.dualMode <= 1'b0;
            s_r.wclkPrev <= 1'b1;
            s_r.rclkPrev <= 1'b1;
            s_r.loadSelAf <= 1'b0;
            s_r.readData <= '0;
            s_r.flags.emptyN <= 1'b0;
            s_r.flags.almostEmptyN <= 1'b0;
            s_r.flags.fullN <= 1'b1;
            s_r.flags.almostFullN <= 1'b1;
            s_r.status <= dcf_pkg::EVT_NONE;
            s_r.mask <= dcf_pkg::EVT_NONE;
            s_r.rdata <= dcf_pkg::READ_ZERO;
        end else begin
            s_r <= s_nxt;
        end
    end

    // storage array carries no reset
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[s_r.wrPtr[ADDR_BITS-1:0]] <= writeDataIn;
        end
    end

    assign readDataOut = s_r.readData;
    assign readDataOutEn = ~outputDriveEnableN;
    assign emptyFlagN = s_r.flags.emptyN;
    assign almostEmptyFlagN = s_r.flags.almostEmptyN;
    assign fullFlagN = s_r.flags.fullN;
    assign almostFullFlagN = s_r.flags.almostFullN;
    assign busRdata = s_r.rdata;
    assign irq = |(s_r.status & s_r.mask);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_full_blocks_write: assert property (wrRefused |=> $stable(s_r.wrPtr))
        else $error("write pointer moved while full");
    a_empty_blocks_read: assert property (rdReq && !emptyFlagN |=> $stable(s_r.rdPtr))
        else $error("read pointer moved while empty");
    a_empty_flag_level: assert property (emptyFlagN == (s_r.count != '0))
        else $error("empty flag disagrees with level");
    a_full_flag_level: assert property (fullFlagN == (s_r.count != DEPTH_CNT))
        else $error("full flag disagrees with level");
    a_almost_empty_level: assert property (almostEmptyFlagN == (s_r.count > s_r.aeOffset))
        else $error("almost-empty flag disagrees with offset");
    a_almost_full_level: assert property (
        almostFullFlagN == (s_r.count < dcf_pkg::CNT_W'(DEPTH_CNT - s_r.afOffset)))
        else $error("almost-full flag disagrees with offset");
    a_read_data_out: assert property (doRead |=> readDataOut == $past(memRd))
        else $error("popped word not presented");
    a_write_count_up: assert property (doWrite && !doRead |=> s_r.count == $past(s_r.count) + 1'b1)
        else $error("write did not raise the level");
    a_dual_gate_write: assert property (
        s_r.dualMode && !secondWriteEnableLoadN && wclkRise |=> $stable(s_r.wrPtr))
        else $error("write taken with second enable low");
    a_strap_held: assert property (s_r.strapped |=> $stable(s_r.dualMode) && s_r.strapped)
        else $error("strap changed after reset");
    a_load_no_push: assert property (doLoad |=> $stable(s_r.wrPtr) && $stable(s_r.count))
        else $error("offset load pushed a word");
    a_drive_follows_oe: assert property (
        $fell(outputDriveEnableN) |-> readDataOutEn ##1 !outputDriveEnableN [*1] |-> readDataOutEn)
        else $error("output drive not following enable");

    // pointer and level bookkeeping
    a_level_bound: assert property (
        s_r.count <= DEPTH_CNT)
        else $error("level beyond depth");
    a_pointer_gap: assert property (
        s_r.count[ADDR_BITS-1:0] == ADDR_BITS'(s_r.wrPtr - s_r.rdPtr))
        else $error("level disagrees with pointers");
    a_write_ptr_step: assert property (
        doWrite |=> s_r.wrPtr == ptrInc($past(s_r.wrPtr)))
        else $error("write pointer did not advance");
    a_write_stores_word: assert property (
        doWrite |=> mem[$past(s_r.wrPtr[ADDR_BITS-1:0])] == $past(writeDataIn))
        else $error("written word not stored");
    a_idle_write_hold: assert property (
        !doWrite |=> $stable(s_r.wrPtr))
        else $error("write pointer moved without a write");
    a_read_ptr_step: assert property (
        doRead |=> s_r.rdPtr == ptrInc($past(s_r.rdPtr)))
        else $error("read pointer did not advance");
    a_read_count_down: assert property (
        doRead && !doWrite |=> s_r.count == $past(s_r.count) - 1'b1)
        else $error("read did not lower the level");
    a_idle_read_hold: assert property (
        !doRead |=> $stable(s_r.rdPtr) && $stable(readDataOut))
        else $error("read side moved without a read");
    a_second_read_gate: assert property (
        rclkRise && secondReadEnableN |=> $stable(s_r.rdPtr) && $stable(readDataOut))
        else $error("read taken with second enable high");

    // write qualification in each strap mode
    a_dual_write_taken: assert property (
        s_r.dualMode && wclkRise && !firstWriteEnableN && secondWriteEnableLoadN
            && fullFlagN && !doRead |=> s_r.count == $past(s_r.count) + 1'b1)
        else $error("dual mode write not taken");
    a_flag_write_taken: assert property (
        s_r.strapped && !s_r.dualMode && wclkRise && !firstWriteEnableN
            && secondWriteEnableLoadN && fullFlagN && !doRead
            |=> s_r.count == $past(s_r.count) + 1'b1)
        else $error("flag mode write not taken");
    a_dual_no_load: assert property (
        s_r.dualMode |-> !loadActive)
        else $error("offset load active in dual mode");
    a_load_no_store: assert property (
        s_r.strapped && !s_r.dualMode && !secondWriteEnableLoadN |-> !doWrite)
        else $error("word stored while offsets load");
    a_load_first_ae: assert property (
        doLoad && !s_r.loadSelAf && !busReq.wr
            |=> s_r.aeOffset == dcf_pkg::CNT_W'($past(writeDataIn)))
        else $error("first offset load missed almost-empty");
    a_strap_capture: assert property (
        $rose(s_r.strapped) |-> s_r.dualMode == $past(secondWriteEnableLoadN))
        else $error("strap did not follow the shared pin");
    a_config_read: assert property (
        busReq.rd && busReq.addr == dcf_pkg::REG_CONFIG
            |=> busRdata == dcf_pkg::BUS_W'($past(s_r.dualMode)))
        else $error("config read disagrees with strap");

    // flag relations and sticky events
    a_empty_implies_ae: assert property (
        !emptyFlagN |-> !almostEmptyFlagN)
        else $error("almost-empty high while empty");
    a_full_implies_af: assert property (
        !fullFlagN |-> !almostFullFlagN)
        else $error("almost-full high while full");
    a_full_not_empty: assert property (
        !fullFlagN |-> emptyFlagN)
        else $error("full and empty together");
    a_empty_needs_write: assert property (
        $rose(emptyFlagN) |-> $past(doWrite))
        else $error("empty flag rose without a write");
    a_full_needs_write: assert property (
        $fell(fullFlagN) |-> $past(doWrite))
        else $error("full flag fell without a write");
    a_full_event: assert property (
        fullFlagN ##1 !fullFlagN |-> s_r.status[dcf_pkg::EVT_FULL])
        else $error("full event not recorded");
    a_empty_event: assert property (
        emptyFlagN ##1 !emptyFlagN |-> s_r.status[dcf_pkg::EVT_EMPTY])
        else $error("empty event not recorded");
    a_wr_refuse_event: assert property (
        wrRefused |=> s_r.status[dcf_pkg::EVT_WR_REFUSED])
        else $error("refused write not recorded");
    a_rd_refuse_event: assert property (
        rdReq && !emptyFlagN |=> s_r.status[dcf_pkg::EVT_RD_REFUSED])
        else $error("refused read not recorded");
    a_oe_released: assert property (
        outputDriveEnableN |-> !readDataOutEn)
        else $error("output driven while disabled");

    // values held while reset is low, skipping the first reset edge
    a_flags_in_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n && $past(!rst_n)
            |-> !emptyFlagN && !almostEmptyFlagN && fullFlagN && almostFullFlagN)
        else $error("flags wrong during reset");
    a_offsets_in_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n && $past(!rst_n)
            |-> s_r.aeOffset == dcf_pkg::AE_OFFSET_RESET
            && s_r.afOffset == dcf_pkg::AF_OFFSET_RESET)
        else $error("offsets not at defaults during reset");

    c_fill_to_full: cover property (fullFlagN ##1 !fullFlagN);
    c_drain_to_empty: cover property (emptyFlagN ##1 !emptyFlagN);
    c_offset_load: cover property (doLoad ##[1:20] doLoad);
    c_irq_raised: cover property (!irq ##1 irq);
    c_write_refused: cover property (wrRefused);
endmodule : dcf_channel

// ---- dv/dcf_side_model.sv ----
/*
 * write-side and read-side logic facing one fifo channel.
 * assumes clk is the system clock of the channel; callers use push and pop.
 */
`timescale 1ns/1ps
module dcf_side_model (
    input wire logic clk,
    output logic writeClock,
    output logic firstWriteEnableN,
    output logic [dcf_pkg::DATA_W-1:0] writeData,
    output logic readClock,
    output logic firstReadEnableN,
    output logic secondReadEnableN
);
    // idle levels before the first transfer
    initial begin
        writeClock = 1'b0;
        firstWriteEnableN = 1'b1;
        writeData = 9'h000;
        readClock = 1'b0;
        firstReadEnableN = 1'b1;
        secondReadEnableN = 1'b1;
    end

    // one word per write edge, only the first enable is used; load level is held by the caller
    task automatic push(input logic [dcf_pkg::DATA_W-1:0] d);
        @(posedge clk);
        writeClock <= 1'b1;
        firstWriteEnableN <= 1'b0;
        writeData <= d;
        @(posedge clk);
        writeClock <= 1'b0;
        firstWriteEnableN <= 1'b1;
        writeData <= ~d; // released data does not keep its value
    endtask : push

    task automatic pop(input logic e2N);
        @(posedge clk);
        readClock <= 1'b1;
        firstReadEnableN <= 1'b0;
        secondReadEnableN <= e2N;
        @(posedge clk);
        readClock <= 1'b0;
        firstReadEnableN <= 1'b1;
        secondReadEnableN <= 1'b1;
    endtask : pop
endmodule : dcf_side_model

// ---- dv/dcf_channel_bench.sv ----
/*
 * self-checking bench for one fifo channel.
 * assumes the side model drives the data ports and the bench owns bus and pins.
 */
`timescale 1ns/1ps
module dcf_channel_bench;
    logic clk;
    logic rst_n;
    logic pinSel;
    logic oeN;
    dcf_pkg::dcf_bus_req_type busReq;
    logic wClk, we1N, rClk, re1N, re2N, rDataEn, emptyN, aEmptyN, fullN, aFullN, irq;
    logic [dcf_pkg::DATA_W-1:0] wData, rData;
    logic [dcf_pkg::BUS_W-1:0] busRdata;
    int error_cnt = 0;
    int checks = 0;
    always #50 clk = ~clk;
    dcf_side_model dcf_side_model_i (.clk(clk), .writeClock(wClk), .firstWriteEnableN(we1N),
        .writeData(wData), .readClock(rClk), .firstReadEnableN(re1N),
        .secondReadEnableN(re2N));
    dcf_channel #(.DEPTH(256)) dcf_channel_i (.clk(clk), .rst_n(rst_n), .write_clock(wClk),
        .firstWriteEnableN(we1N), .secondWriteEnableLoadN(pinSel), .writeDataIn(wData),
        .read_clock(rClk), .firstReadEnableN(re1N), .secondReadEnableN(re2N),
        .outputDriveEnableN(oeN), .readDataOut(rData), .readDataOutEn(rDataEn),
        .emptyFlagN(emptyN), .almostEmptyFlagN(aEmptyN), .fullFlagN(fullN),
        .almostFullFlagN(aFullN), .busReq(busReq), .busRdata(busRdata), .irq(irq));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : busWr

    task automatic busRd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk(name, busRdata, exp);
    endtask : busRd

    task automatic doReset(input logic pin);
        @(posedge clk);
        pinSel <= pin;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("reset flags", {emptyN, aEmptyN, fullN, aFullN}, 32'h3);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : doReset

    task automatic dualModeCase;
        doReset(1'b1);
        busRd("config dual", dcf_pkg::REG_CONFIG, 32'h1);
        pinSel <= 1'b0;
        dcf_side_model_i.push(9'h1a5);
        busRd("level second enable low", dcf_pkg::REG_LEVEL, 32'h0);
        pinSel <= 1'b1;
        dcf_side_model_i.push(9'h15a);
        #1 chk("empty after write", emptyN, 32'h1);
        dcf_side_model_i.pop(1'b1);
        #1 chk("no pop one enable high", rData, 32'h0);
        dcf_side_model_i.pop(1'b0);
        #1 chk("popped word", rData, 32'h15a);
        chk("empty again", emptyN, 32'h0);
        oeN <= 1'b1;
        #1 chk("output released", rDataEn, 32'h0);
        oeN <= 1'b0;
        #1 chk("output driven", rDataEn, 32'h1);
        busRd("unmapped read", 8'h20, 32'h0);
    endtask : dualModeCase

    task automatic flagModeCase;
        doReset(1'b0);
        busRd("config flag", dcf_pkg::REG_CONFIG, 32'h0);
        dcf_side_model_i.push(9'h003);
        pinSel <= 1'b1;
        busRd("ae offset loaded", dcf_pkg::REG_AE_OFFSET, 32'h3);
        busRd("level after load", dcf_pkg::REG_LEVEL, 32'h0);
        for (int i = 1; i <= 4; i++) begin
            dcf_side_model_i.push(i[8:0]);
            #1 chk("ae programmed", aEmptyN, {31'h0, i > 3});
        end
    endtask : flagModeCase

    task automatic fillDrainCase;
        doReset(1'b1);
        for (int n = 1; n <= 256; n++) begin
            dcf_side_model_i.push(9'((n - 1) * 3));
            #1 chk("af level", aFullN, {31'h0, n < 249});
            chk("full level", fullN, {31'h0, n < 256});
        end
        dcf_side_model_i.push(9'h1ff);
        busRd("level stays full", dcf_pkg::REG_LEVEL, 32'h100);
        busRd("status write refused", dcf_pkg::REG_STATUS, 32'h5);
        for (int n = 255; n >= 0; n--) begin
            dcf_side_model_i.pop(1'b0);
            #1 chk("fifo order", rData, {23'h0, 9'((255 - n) * 3)});
            chk("ae drain", aEmptyN, {31'h0, n > 7});
            chk("empty drain", emptyN, {31'h0, n > 0});
        end
        dcf_side_model_i.pop(1'b0);
        #1 chk("read refused keeps word", rData, 32'h0fd);
        busRd("status read refused", dcf_pkg::REG_STATUS, 32'hf);
        busWr(dcf_pkg::REG_MASK, 32'h2);
        #1 chk("irq unmasked", irq, 32'h1);
        busWr(dcf_pkg::REG_STATUS, 32'hf);
        busRd("status cleared", dcf_pkg::REG_STATUS, 32'h0);
        chk("irq cleared", irq, 32'h0);
    endtask : fillDrainCase

    initial begin
        #(100 * 100000);
        error_cnt++;
        end_sim();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        pinSel = 1'b1;
        oeN = 1'b0;
        busReq = '0;
        dualModeCase();
        flagModeCase();
        fillDrainCase();
        end_sim();
    end
endmodule : dcf_channel_bench
